// File: src/agc_config_top.sv
// Gain and offset configuration registers with per-channel datapath
// How it works
// - Output samples are scaled by the 4-bit gain before decimation.
// - Each gain code up to 11 adds 1 dB; code 0 is 0 dB, codes 11 to 15 are 11 dB.
// - Bit 0 of estimate-source register selects external offset estimate.
// - Hold pattern 111 freezes the estimate and keeps last value applied.
// - Disable bit clear: corrector active, removes fs/8, fs/4, 3fs/8, fs/2 spurs.
// - Disable bit set: corrector bypassed, no offset removed.
// - Gain registers exist per channel, A page and B page.
// - Channel A offset registers sit on the channel A page.
`timescale 1ns/10ps
module agc_config_top
  import agc_pkg::*;
#(
  parameter int unsigned SW = 14
)(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [agc_addr_w-1:0] reg_addr,
  input wire logic [agc_data_w-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [agc_data_w-1:0] reg_rdata,
  input wire logic a_valid,
  input wire logic signed [SW-1:0] a_data,
  input wire logic signed [SW-1:0] a_ext_estimate,
  input wire logic b_valid,
  input wire logic signed [SW-1:0] b_data,
  output logic a_out_valid,
  output logic signed [SW-1:0] a_out_data,
  output logic b_out_valid,
  output logic signed [SW-1:0] b_out_data,
  output logic low_rate_enable_two,
  output logic a_offset_frozen
);
  logic [7:0] low_rate_reg, low_rate_next;
  logic [7:0] est_src_reg, est_src_next;
  logic [7:0] corr_ctl_reg, corr_ctl_next;
  logic [7:0] gain_a_reg, gain_a_next;
  logic [7:0] gain_b_reg, gain_b_next;
  logic [7:0] rdata_reg, rdata_next;
  logic page_b;
  logic [9:0] off;
  logic [2:0] hold_bits;
  logic freeze;
  logic a_gain_valid;
  logic signed [SW-1:0] a_gain_data;

  assign page_b = reg_addr[agc_page_bit];
  assign off = {2'b00, reg_addr[7:0]};

  // Register writes; reserved bits masked off
  always_comb
  begin
    low_rate_next = low_rate_reg;
    est_src_next = est_src_reg;
    corr_ctl_next = corr_ctl_reg;
    gain_a_next = gain_a_reg;
    gain_b_next = gain_b_reg;
    if (reg_write)
    begin
      case (off)
        agc_off_low_rate: low_rate_next = reg_wdata & agc_mask_low_rate;
        agc_off_est_src: if (!page_b) est_src_next = reg_wdata & agc_mask_est_src;
        agc_off_corr_ctl: if (!page_b) corr_ctl_next = reg_wdata & agc_mask_corr_ctl;
        agc_off_gain:
        begin
          if (page_b) gain_b_next = reg_wdata & agc_mask_gain;
          else gain_a_next = reg_wdata & agc_mask_gain;
        end
        default: ;
      endcase
    end
  end

  // Read mux, data valid the cycle after the strobe; unmapped reads zero
  always_comb
  begin
    rdata_next = rdata_reg;
    if (reg_read)
    begin
      case (off)
        agc_off_low_rate: rdata_next = low_rate_reg;
        agc_off_est_src: rdata_next = page_b ? 8'h00 : est_src_reg;
        agc_off_corr_ctl: rdata_next = page_b ? 8'h00 : corr_ctl_reg;
        agc_off_gain: rdata_next = page_b ? gain_b_reg : gain_a_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Register file state
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      low_rate_reg <= agc_reset_val;
      est_src_reg <= agc_reset_val;
      corr_ctl_reg <= agc_reset_val;
      gain_a_reg <= agc_reset_val;
      gain_b_reg <= agc_reset_val;
      rdata_reg <= agc_reset_val;
    end
    else
    begin
      low_rate_reg <= low_rate_next;
      est_src_reg <= est_src_next;
      corr_ctl_reg <= corr_ctl_next;
      gain_a_reg <= gain_a_next;
      gain_b_reg <= gain_b_next;
      rdata_reg <= rdata_next;
    end
  end

  // Hold decode: only 111 freezes; 011 and reserved patterns run
  assign hold_bits = {corr_ctl_reg[agc_freeze_bit], corr_ctl_reg[agc_must1_hi_bit],
                      corr_ctl_reg[agc_must1_lo_bit]};
  assign freeze = (hold_bits == agc_hold_freeze);
  assign reg_rdata = rdata_reg;
  assign low_rate_enable_two = low_rate_reg[agc_low_rate_bit];
  assign a_offset_frozen = freeze;

  // Channel A: gain then offset correction
  agc_gain_stage #(.SW(SW)) u_gain_a (
    .clock(clock),
    .rstn(rstn),
    .gain_code(gain_a_reg[3:0]),
    .in_valid(a_valid),
    .in_data(a_data),
    .out_valid(a_gain_valid),
    .out_data(a_gain_data)
  );

  agc_offset_corr #(.SW(SW)) u_corr_a (
    .clock(clock),
    .rstn(rstn),
    .ext_select(est_src_reg[agc_ext_est_bit]),
    .freeze(freeze),
    .bypass(corr_ctl_reg[agc_disable_bit]),
    .ext_estimate(a_ext_estimate),
    .in_valid(a_gain_valid),
    .in_data(a_gain_data),
    .out_valid(a_out_valid),
    .out_data(a_out_data),
    .estimate()
  );

  // Channel B: gain only
  agc_gain_stage #(.SW(SW)) u_gain_b (
    .clock(clock),
    .rstn(rstn),
    .gain_code(gain_b_reg[3:0]),
    .in_valid(b_valid),
    .in_data(b_data),
    .out_valid(b_out_valid),
    .out_data(b_out_data)
  );
endmodule : agc_config_top

// File: src/agc_gain_stage.sv
// Digital gain stage applied to one channel's samples ahead of decimation
`timescale 1ns/10ps
module agc_gain_stage
  import agc_pkg::*;
#(
  parameter int unsigned SW = 14
)(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] gain_code,
  input wire logic in_valid,
  input wire logic signed [SW-1:0] in_data,
  output logic out_valid,
  output logic signed [SW-1:0] out_data
);
  logic signed [SW-1:0] data_reg, data_next;
  logic valid_reg, valid_next;
  logic signed [SW+18:0] prod;
  logic signed [SW+18:0] scaled;
  logic [17:0] coef;
  localparam logic signed [SW+18:0] sat_hi = (SW+19)'((1 <<< (SW-1)) - 1);
  localparam logic signed [SW+18:0] sat_lo = -(SW+19)'(1 <<< (SW-1));

  // Multiply by the gain for the code, saturate to sample width
  always_comb
  begin
    coef = (gain_code > agc_gain_max) ? agc_gain_lut[11] : agc_gain_lut[gain_code];
    prod = in_data * $signed({1'b0, coef});
    scaled = prod >>> agc_gain_frac;
    valid_next = in_valid;
    data_next = data_reg;
    if (in_valid)
    begin
      if (scaled > sat_hi)
        data_next = sat_hi[SW-1:0];
      else if (scaled < sat_lo)
        data_next = sat_lo[SW-1:0];
      else
        data_next = scaled[SW-1:0];
    end
  end

  // Output registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      data_reg <= '0;
      valid_reg <= 1'b0;
    end
    else
    begin
      data_reg <= data_next;
      valid_reg <= valid_next;
    end
  end

  assign out_valid = valid_reg;
  assign out_data = data_reg;
endmodule : agc_gain_stage

// File: src/agc_offset_corr.sv
// Offset corrector for one channel: running estimate, freeze, external estimate, bypass
`timescale 1ns/10ps
module agc_offset_corr
  import agc_pkg::*;
#(
  parameter int unsigned SW = 14
)(
  input wire logic clock,
  input wire logic rstn,
  input wire logic ext_select,
  input wire logic freeze,
  input wire logic bypass,
  input wire logic signed [SW-1:0] ext_estimate,
  input wire logic in_valid,
  input wire logic signed [SW-1:0] in_data,
  output logic out_valid,
  output logic signed [SW-1:0] out_data,
  output logic signed [SW-1:0] estimate
);
  // Accumulator width: sample width plus leak shift
  localparam int unsigned AW = SW + agc_est_shift;
  logic signed [AW-1:0] acc_reg [0:7];
  logic signed [AW-1:0] acc_next [0:7];
  logic [2:0] phase_reg, phase_next;
  logic signed [SW-1:0] data_reg, data_next;
  logic valid_reg, valid_next;
  logic signed [SW-1:0] own_est;
  logic signed [SW-1:0] used_est;
  logic signed [SW:0] diff;

  // Leaky mean per sample phase; an 8-sample periodic offset covers DC to fs/2
  always_comb
  begin
    own_est = acc_reg[phase_reg][AW-1:agc_est_shift];
    used_est = ext_select ? ext_estimate : own_est;
    acc_next = acc_reg;
    phase_next = in_valid ? phase_reg + 3'h1 : phase_reg;
    if (in_valid && !freeze && !bypass)
      acc_next[phase_reg] = acc_reg[phase_reg] + AW'(in_data) - AW'(own_est);
    diff = {in_data[SW-1], in_data} - {used_est[SW-1], used_est};
    valid_next = in_valid;
    data_next = data_reg;
    if (in_valid)
    begin
      if (bypass)
        data_next = in_data;
      else if (diff[SW] != diff[SW-1])
        data_next = diff[SW] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
      else
        data_next = diff[SW-1:0];
    end
  end

  // Estimate and output registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      acc_reg <= '{default: '0};
      phase_reg <= 3'h0;
      data_reg <= '0;
      valid_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= acc_next;
      phase_reg <= phase_next;
      data_reg <= data_next;
      valid_reg <= valid_next;
    end
  end

  assign out_valid = valid_reg;
  assign out_data = data_reg;
  assign estimate = own_est;
endmodule : agc_offset_corr

// File: src/agc_pkg.sv
// Package with register map, field positions and gain constants for the config block
package agc_pkg;
  localparam int unsigned agc_addr_w = 10;
  localparam int unsigned agc_data_w = 8;
  // Register offsets within a page
  localparam logic [9:0] agc_off_est_src = 10'h034;
  localparam logic [9:0] agc_off_low_rate = 10'h042;
  localparam logic [9:0] agc_off_corr_ctl = 10'h068;
  localparam logic [9:0] agc_off_gain = 10'h0a6;
  // Page select bit in the address: 0 channel A page, 1 channel B page
  localparam int unsigned agc_page_bit = 8;
  // Field positions
  localparam int unsigned agc_low_rate_bit = 4;
  localparam int unsigned agc_ext_est_bit = 0;
  localparam int unsigned agc_freeze_bit = 7;
  localparam int unsigned agc_must1_hi_bit = 5;
  localparam int unsigned agc_disable_bit = 2;
  localparam int unsigned agc_must1_lo_bit = 1;
  // Writable masks (other bits reserved, read zero)
  localparam logic [7:0] agc_mask_est_src = 8'h01;
  localparam logic [7:0] agc_mask_low_rate = 8'h10;
  localparam logic [7:0] agc_mask_corr_ctl = 8'ha6;
  localparam logic [7:0] agc_mask_gain = 8'h0f;
  localparam logic [7:0] agc_reset_val = 8'h00;
  // Gain codes and hold patterns
  localparam logic [3:0] agc_gain_max = 4'hb;
  localparam logic [2:0] agc_hold_run = 3'h3;
  localparam logic [2:0] agc_hold_freeze = 3'h7;
  // Gain step of 1 dB in Q4.14: 10^(k/20)
  localparam int unsigned agc_gain_frac = 14;
  localparam logic [17:0] agc_gain_lut [0:11] = '{
    18'h04000, 18'h047cf, 18'h05092, 18'h05a67, 18'h06570, 18'h071cf,
    18'h07fb2, 18'h08f47, 18'h0a0c3, 18'h0b460, 18'h0ca63, 18'h0e315};
  localparam int unsigned agc_est_shift = 6;
endpackage : agc_pkg

// File: verification/agc_config_chk.sv
// Port checker for the gain and offset configuration block
`timescale 1ns/10ps
module agc_config_chk
  import agc_pkg::*;
#(
  parameter int unsigned SW = 14
)(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [agc_addr_w-1:0] reg_addr,
  input wire logic [agc_data_w-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [agc_data_w-1:0] reg_rdata,
  input wire logic a_valid,
  input wire logic signed [SW-1:0] a_data,
  input wire logic signed [SW-1:0] a_ext_estimate,
  input wire logic b_valid,
  input wire logic signed [SW-1:0] b_data,
  input wire logic a_out_valid,
  input wire logic signed [SW-1:0] a_out_data,
  input wire logic b_out_valid,
  input wire logic signed [SW-1:0] b_out_data,
  input wire logic low_rate_enable_two,
  input wire logic a_offset_frozen
);
  logic [3:0] gb_reg;
  logic [3:0] gb_next;
  wire w68 = reg_write && reg_addr[8:0] == 9'h068;
  wire lr_bit = reg_wdata[4];
  // Shadow of the channel B gain code
  always_comb
  begin
    gb_next = gb_reg;
    if (reg_write && reg_addr[8:0] == 9'h1a6)
      gb_next = reg_wdata[3:0];
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      gb_reg <= 4'h0;
    else
      gb_reg <= gb_next;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Latencies, register effects and holds
  b_lat_a: assert property (1 |=> b_out_valid == $past(b_valid)) else $error("b latency");
  a_lat_a: assert property (a_valid |-> ##2 a_out_valid) else $error("a latency");
  low_rate_a: assert property (reg_write && reg_addr[7:0] == 8'h42 |=>
    low_rate_enable_two == $past(lr_bit)) else $error("low rate bit");
  freeze_on_a: assert property (w68 && reg_wdata[7] && reg_wdata[5] && reg_wdata[1] |=>
    a_offset_frozen) else $error("freeze not set");
  freeze_off_a: assert property (w68 && !reg_wdata[7] |=> !a_offset_frozen)
    else $error("freeze not cleared");
  page_b_a: assert property (reg_write && reg_addr[8:0] == 9'h168 |=>
    $stable(a_offset_frozen)) else $error("page B reached A");
  rd_hold_a: assert property (!reg_read |=> $stable(reg_rdata)) else $error("rdata moved");
  unity_b_a: assert property (b_valid && gb_reg == 4'h0 |=> b_out_data == $past(b_data))
    else $error("0 dB not unity");
  cover property (w68 && reg_wdata == 8'ha2);
  cover property (b_valid && gb_reg == 4'hf);
  cover property (reg_read && reg_addr[8:0] == 9'h168);
endmodule : agc_config_chk

// File: verification/test_adc_gain_offset_config_regs.sv
// Self-checking bench for the gain and offset configuration block
`timescale 1ns/10ps
module test_adc_gain_offset_config_regs;
  import agc_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic a_valid = 1'b0;
  logic b_valid = 1'b0;
  logic signed [13:0] a_data = 14'h0000;
  logic signed [13:0] b_data = 14'h0000;
  logic signed [13:0] a_ext_estimate = 14'h0064;
  logic [7:0] reg_rdata;
  logic a_out_valid, b_out_valid, low_rate_enable_two, a_offset_frozen;
  logic signed [13:0] a_out_data, b_out_data;
  int fail_count = 0;
  int check_count = 0;
  int seed = 18;
  int cycles = 0;
  int model [0:511];
  int d;
  int ns = 0;
  logic signed [31:0] as, bs;
  logic [9:0] at [9] = '{10'h034, 10'h042, 10'h068, 10'h0a6, 10'h134, 10'h142, 10'h168,
    10'h1a6, 10'h0ff};
  agc_config_top #(.SW(14)) DUT (.*);
  always #2 clock = ~clock;
  // Register image: the low-rate bit is shared, page B offset space is absent
  function automatic int ix(input logic [9:0] a);
    return (a[7:0] == 8'h42) ? 9'h042 : a[8:0];
  endfunction : ix
  function automatic int msk(input int a);
    case (a)
      9'h034: return 8'h01;
      9'h042: return 8'h10;
      9'h068: return 8'ha6;
      9'h0a6, 9'h1a6: return 8'h0f;
      default: return 0;
    endcase
  endfunction : msk
  // Legal random value: reserved bits zero, hold bits 5 and 1 set
  function automatic logic [7:0] legal(input logic [9:0] a, input logic [7:0] v);
    logic [7:0] m;
    m = (a[7:0] == 8'h68) ? 8'ha6 : 8'(msk(ix(a)));
    return (v & m) | ((a[7:0] == 8'h68) ? 8'h22 : 8'h00);
  endfunction : legal
  // Expected gain, codes above 11 clamp
  function automatic int gx(input int v, input int k);
    return $rtoi(v * 10.0 ** ((k > 11 ? 11 : k) / 20.0));
  endfunction : gx
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] expd);
    check_count++;
    if (seen !== expd)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, expd, seen);
    end
  endtask : check
  task automatic finish_test();
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Bus write, then settle
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    model[ix(a)] = v & msk(ix(a));
    @(negedge clock);
  endtask : wr
  task automatic rd(input logic [9:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    check("reg_rdata", reg_rdata, model[ix(a)]);
  endtask : rd
  // One sample on both channels
  task automatic smp(input int a, input int b);
    ns++;
    @(posedge clock);
    a_data <= a[13:0];
    b_data <= b[13:0];
    a_valid <= 1'b1;
    b_valid <= 1'b1;
    @(posedge clock);
    a_valid <= 1'b0;
    b_valid <= 1'b0;
    @(negedge clock);
    bs = b_out_data;
    check("b_out_valid", b_out_valid, 1);
    @(negedge clock);
    as = a_out_data;
    check("a_out_valid", a_out_valid, 1);
  endtask : smp
  // Hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fail_count++;
      finish_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    wr(10'h068, 8'h22);
    for (int p = 0; p < 3; p++)
    begin
      foreach (at[i])
        rd(at[i]);
      foreach (at[i])
        wr(at[i], legal(at[i], 8'($random(seed))));
    end
    wr(10'h042, 8'h10);
    check("low_rate", low_rate_enable_two, 1);
    wr(10'h142, 8'h00);
    check("low_rate", low_rate_enable_two, 0);
    wr(10'h068, 8'ha2);
    check("frozen", a_offset_frozen, 1);
    wr(10'h168, 8'h22);
    check("frozen", a_offset_frozen, 1);
    wr(10'h068, 8'h26);
    check("frozen", a_offset_frozen, 0);
    for (int k = 0; k < 16; k++)
    begin
      wr(10'h0a6, 8'(k));
      wr(10'h1a6, 8'(15 - k));
      repeat (3)
      begin
        d = $random(seed) % 1000;
        smp(d, -d);
        check("a_gain", (as - gx(d, k)) inside {[-1:1]}, 1);
        check("b_gain", (bs - gx(-d, 15 - k)) inside {[-1:1]}, 1);
      end
    end
    wr(10'h0a6, 8'h00);
    wr(10'h034, 8'h00);
    wr(10'h068, 8'h22);
    // DC of 400 plus an fs/2 offset tone of 96
    repeat (4000) smp(ns[0] ? 496 : 304, 0);
    check("dc_removed", as inside {[-64:64]}, 1);
    wr(10'h068, 8'ha2);
    repeat (100) smp(ns[0] ? 696 : 504, 0);
    check("held_est", as inside {[136:264]}, 1);
    wr(10'h034, 8'h01);
    wr(10'h068, 8'h22);
    repeat (3) smp(600, 0);
    check("ext_est", as inside {[499:501]}, 1);
    finish_test();
  end
endmodule : test_adc_gain_offset_config_regs
bind agc_config_top agc_config_chk #(.SW(SW)) u_chk (.*);
